// ### design/dpm_port_mux.sv
// Purpose: port b / port z pin function mux with avalon-mm registers
// Assumes: pins arrive asynchronous and are synchronised here
// Notes:   one wait state on every access; open drain not supported
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dpm_port_mux (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // avalon-mm slave
    input  wire logic [9:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // port b pins
    input  wire logic [3:0]  portb_pin_i,
    output logic      [3:0]  portb_pin_o,
    output logic      [3:0]  portb_pin_oe_o,
    // port z pins
    input  wire logic [3:0]  portz_pin_i,
    output logic      [3:0]  portz_pin_o,
    output logic      [3:0]  portz_pin_oe_o,
    output logic      [3:0]  portz_pullup_o,
    // on-chip peripherals
    output logic             timer4_capture_in0_o,
    output logic             timer4_capture_in1_o,
    output logic             ext_irq_nine_o,
    output logic             ext_irq_ten_o,
    input  wire logic        timer4_flop_out0_i,
    input  wire logic        timer4_flop_out1_i,
    input  wire logic        serial_bus_data_line_i,
    input  wire logic        serial_bus_data_oe_i,
    output logic             serial_bus_data_line_o,
    input  wire logic        serial_bus_clock_line_i,
    input  wire logic        serial_bus_clock_oe_i,
    output logic             serial_bus_clock_line_o,
    // cpu bus strobes, active low, with access area
    input  wire logic        cpu_rd_n_i,
    input  wire logic        cpu_wr_n_i,
    input  wire logic        cpu_hwr_n_i,
    input  wire logic        cpu_rw_i,
    input  wire logic        cpu_external_i
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [3:0]  pb_latch;
        logic [3:0]  pb_dir;
        logic [3:0]  pb_alt;
        logic [1:0]  pb_alt2;
        logic [3:0]  pz_latch;
        logic [3:0]  pz_dir;
        logic [3:0]  pz_alt;
        logic [3:0]  pb_meta;
        logic [3:0]  pb_sync;
        logic [3:0]  pz_meta;
        logic [3:0]  pz_sync;
        logic        ack;
        logic [31:0] rdata;
    } dpm_state_t;

    dpm_state_t state_ff;
    dpm_state_t nxt_state;

    logic [7:0]  idx;
    logic        req;
    logic [3:0]  pb_o, pb_oe, pz_o, pz_oe;
    logic [3:0]  pb_in_mode, pz_in_mode;
    logic        rd_strobe_n;

    assign idx = avs_address_i[9:2];
    assign req = (avs_read_i | avs_write_i) & ~state_ff.ack;

    // ----------------------------------------
    // port b function decode
    // ----------------------------------------
    always_comb begin
        pb_o  = state_ff.pb_latch;
        pb_oe = 4'h0;
        pb_in_mode = 4'h0;
        for (int i = 0; i < 4; i++) begin
            // bit x of each register steers pin x
            if (i < 2) begin
                logic [2:0] sel;
                sel = {state_ff.pb_dir[i], state_ff.pb_alt[i], state_ff.pb_alt2[i]};
                if (sel == 3'b000 || sel == 3'b010) begin
                    pb_in_mode[i] = 1'b1;
                end else if (sel == 3'b100) begin
                    pb_oe[i] = 1'b1;
                end else if (sel == 3'b101) begin
                    // open-drain serial lines follow the serial block's enable
                    pb_o[i]  = (i == 0) ? serial_bus_data_line_i : serial_bus_clock_line_i;
                    pb_oe[i] = (i == 0) ? serial_bus_data_oe_i : serial_bus_clock_oe_i;
                end else begin
                    pb_in_mode[i] = 1'b1;
                end
            end else begin
                if (!state_ff.pb_dir[i]) begin
                    pb_in_mode[i] = 1'b1;
                end else if (!state_ff.pb_alt[i]) begin
                    pb_oe[i] = 1'b1;
                end else begin
                    // alternate only after alternate bit written one
                    pb_o[i]  = (i == 2) ? timer4_flop_out0_i : timer4_flop_out1_i;
                    pb_oe[i] = 1'b1;
                end
            end
        end
    end

    // capture and irq only see the pin when the input alternate is picked
    assign timer4_capture_in0_o = state_ff.pb_sync[0] & ~state_ff.pb_dir[0]
                                  & state_ff.pb_alt[0] & ~state_ff.pb_alt2[0];
    assign timer4_capture_in1_o = state_ff.pb_sync[1] & ~state_ff.pb_dir[1]
                                  & state_ff.pb_alt[1] & ~state_ff.pb_alt2[1];
    assign ext_irq_nine_o = timer4_capture_in0_o;
    assign ext_irq_ten_o  = timer4_capture_in1_o;
    assign serial_bus_data_line_o  = state_ff.pb_sync[0];
    assign serial_bus_clock_line_o = state_ff.pb_sync[1];

    // ----------------------------------------
    // port z function decode
    // ----------------------------------------
    // latch bit 0 set masks the read strobe on internal accesses
    assign rd_strobe_n = (state_ff.pz_latch[0] && !cpu_external_i) ? 1'b1 : cpu_rd_n_i;

    always_comb begin
        pz_o = state_ff.pz_latch;
        pz_oe = 4'h3;                         // pins 0,1 always driven
        pz_in_mode = 4'h0;
        // plain latch output when function clear
        if (state_ff.pz_alt[0]) begin
            pz_o[0] = rd_strobe_n;
        end
        if (state_ff.pz_alt[1]) begin
            pz_o[1] = cpu_external_i ? cpu_wr_n_i : 1'b1;
        end
        if (state_ff.pz_alt[2] && state_ff.pz_dir[2]) begin
            pz_o[2] = cpu_external_i ? cpu_hwr_n_i : 1'b1;
            pz_oe[2] = 1'b1;
        end else if (!state_ff.pz_alt[2] && state_ff.pz_dir[2]) begin
            pz_oe[2] = 1'b1;
        end else begin
            pz_in_mode[2] = 1'b1;
        end
        if (state_ff.pz_alt[3] && !state_ff.pz_dir[3]) begin
            pz_o[3] = cpu_rw_i;
            pz_oe[3] = 1'b1;
        end else if (!state_ff.pz_alt[3] && state_ff.pz_dir[3]) begin
            pz_oe[3] = 1'b1;
        end else begin
            pz_in_mode[3] = 1'b1;
        end
    end

    assign portb_pin_o    = pb_o;
    assign portb_pin_oe_o = pb_oe;
    assign portz_pin_o    = pz_o;
    assign portz_pin_oe_o = pz_oe;
    // pull-up only on an input, enabled by latch one
    assign portz_pullup_o = pz_in_mode & state_ff.pz_latch;

    // ----------------------------------------
    // register file and synchronisers
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        // two stages before any logic reads a pin
        nxt_state.pb_meta = portb_pin_i;
        nxt_state.pb_sync = state_ff.pb_meta;
        nxt_state.pz_meta = portz_pin_i;
        nxt_state.pz_sync = state_ff.pz_meta;
        nxt_state.ack = req;
        if (req && avs_write_i && avs_byteenable_i[0]) begin
            // direction/alternate are write-only, so rmw would corrupt them
            if (idx == dpm_pkg::IDX_PB_DATA) begin
                nxt_state.pb_latch = avs_writedata_i[3:0];
            end else if (idx == dpm_pkg::IDX_PB_ALT2) begin
                nxt_state.pb_alt2 = avs_writedata_i[1:0];
            end else if (idx == dpm_pkg::IDX_PB_DIR) begin
                nxt_state.pb_dir = avs_writedata_i[3:0];
            end else if (idx == dpm_pkg::IDX_PB_ALT) begin
                nxt_state.pb_alt = avs_writedata_i[3:0];
            end else if (idx == dpm_pkg::IDX_PZ_DATA) begin
                nxt_state.pz_latch = avs_writedata_i[3:0];
            end else if (idx == dpm_pkg::IDX_PZ_DIR) begin
                nxt_state.pz_dir = {avs_writedata_i[3:2], 2'b00};
            end else if (idx == dpm_pkg::IDX_PZ_ALT) begin
                nxt_state.pz_alt = avs_writedata_i[3:0];
            end
        end
        nxt_state.rdata = dpm_pkg::RD_UNMAPPED;
        if (req && avs_read_i) begin
            // data reads return pin levels, not the latch
            if (idx == dpm_pkg::IDX_PB_DATA) begin
                nxt_state.rdata = {28'h0, state_ff.pb_sync};
            end else if (idx == dpm_pkg::IDX_PZ_DATA) begin
                nxt_state.rdata = {28'h0, state_ff.pz_sync};
            end
        end
        if (sys_rst_i) begin
            nxt_state = '0;
            nxt_state.pb_latch = dpm_pkg::RST_LATCH;
            nxt_state.pb_dir   = dpm_pkg::RST_CTRL;
            nxt_state.pb_alt   = dpm_pkg::RST_CTRL;
            nxt_state.pb_alt2  = dpm_pkg::RST_ALT2;
            nxt_state.pz_latch = dpm_pkg::RST_LATCH;
            nxt_state.pz_dir   = dpm_pkg::RST_CTRL;
            nxt_state.pz_alt   = dpm_pkg::RST_CTRL;
        end
    end

    always_ff @(posedge clk_i) begin
        state_ff <= nxt_state;
    end

    assign avs_waitrequest_o = req;
    assign avs_readdata_o    = state_ff.rdata;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_reset_latch: assert property (@(posedge clk_i) sys_rst_i |=>
        state_ff.pb_latch == 4'hf && portb_pin_oe_o == 4'h0)
        else $error("port b not input with ones after reset");
    a_reset_ctrl: assert property (@(posedge clk_i) sys_rst_i |=>
        state_ff.pb_dir == 4'h0 && state_ff.pb_alt == 4'h0)
        else $error("port b control not cleared");
    a_timer_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pb_dir[2] && state_ff.pb_alt[2]) |-> portb_pin_o[2] == timer4_flop_out0_i)
        else $error("timer flop not on pin 2");
    a_irq_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!state_ff.pb_dir[0] && state_ff.pb_alt[0] && !state_ff.pb_alt2[0])
        |-> ext_irq_nine_o == state_ff.pb_sync[0])
        else $error("irq nine not following pin");
    a_pz_reset: assert property (@(posedge clk_i) sys_rst_i |=>
        portz_pin_o[1:0] == 2'b11 && portz_pullup_o == 4'hc)
        else $error("port z reset state wrong");
    a_rd_internal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[0] && !state_ff.pz_latch[0]) |-> portz_pin_o[0] == cpu_rd_n_i)
        else $error("read strobe not always driven");
    a_wr_external: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[1] && !cpu_external_i) |-> portz_pin_o[1])
        else $error("write strobe on internal access");
    a_read_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (avs_read_i && req && idx == dpm_pkg::IDX_PB_DATA)
        |=> avs_readdata_o == {28'h0, $past(state_ff.pb_sync)})
        else $error("port b read not pin levels");
    // ----------------------------------------
    // port b register and pin decode checks; port z data read
    // ----------------------------------------
    a_pb_alt2_reset: assert property (@(posedge clk_i) sys_rst_i |=>
        state_ff.pb_alt2 == 2'h0)
        else $error("port b second alternate not cleared");
    // a write to alternate or direction must land in the register it addresses
    a_alt_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (req && avs_write_i && avs_byteenable_i[0] && idx == dpm_pkg::IDX_PB_ALT)
        |=> state_ff.pb_alt == $past(avs_writedata_i[3:0]))
        else $error("alternate register write lost");
    a_dir_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (req && avs_write_i && avs_byteenable_i[0] && idx == dpm_pkg::IDX_PB_DIR)
        |=> state_ff.pb_dir == $past(avs_writedata_i[3:0]))
        else $error("direction register write lost");
    a_pb_plain_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pb_dir[0] && !state_ff.pb_alt[0] && !state_ff.pb_alt2[0])
        |-> portb_pin_oe_o[0] && portb_pin_o[0] == state_ff.pb_latch[0])
        else $error("port b pin 0 not a plain output");
    a_pb_alt_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !state_ff.pb_alt[2] |-> portb_pin_o[2] == state_ff.pb_latch[2])
        else $error("pin 2 left the latch without alternate bit");
    a_pb_lo_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pb_dir[0] && state_ff.pb_alt[0]) |-> !portb_pin_oe_o[0])
        else $error("reserved pin 0 setting drives");
    a_pb_hi_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!state_ff.pb_dir[3] && state_ff.pb_alt[3]) |-> !portb_pin_oe_o[3])
        else $error("reserved pin 3 setting drives");
    a_timer_out1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pb_dir[3] && state_ff.pb_alt[3])
        |-> portb_pin_oe_o[3] && portb_pin_o[3] == timer4_flop_out1_i)
        else $error("timer flop not on pin 3");
    // open-drain behaviour comes from the serial block's enable, not from here
    a_serial_data: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pb_dir[0] && !state_ff.pb_alt[0] && state_ff.pb_alt2[0])
        |-> portb_pin_o[0] == serial_bus_data_line_i
        && portb_pin_oe_o[0] == serial_bus_data_oe_i)
        else $error("serial data not on pin 0");
    a_serial_clock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pb_dir[1] && !state_ff.pb_alt[1] && state_ff.pb_alt2[1])
        |-> portb_pin_o[1] == serial_bus_clock_line_i
        && portb_pin_oe_o[1] == serial_bus_clock_oe_i)
        else $error("serial clock not on pin 1");
    a_serial_in: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        serial_bus_data_line_o == state_ff.pb_sync[0]
        && serial_bus_clock_line_o == state_ff.pb_sync[1])
        else $error("serial lines not fed from pins");
    a_irq_ten: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!state_ff.pb_dir[1] && state_ff.pb_alt[1] && !state_ff.pb_alt2[1])
        |-> ext_irq_ten_o == state_ff.pb_sync[1] && timer4_capture_in1_o == state_ff.pb_sync[1])
        else $error("irq ten not following pin");
    a_capture_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff.pb_dir[0] |-> !timer4_capture_in0_o && !ext_irq_nine_o)
        else $error("capture seen while pin 0 drives");
    a_pz_read_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (avs_read_i && req && idx == dpm_pkg::IDX_PZ_DATA)
        |=> avs_readdata_o == {28'h0, $past(state_ff.pz_sync)})
        else $error("port z read not pin levels");

    // ----------------------------------------
    // port z register and pin decode checks
    // ----------------------------------------
    a_pz_reset_ctrl: assert property (@(posedge clk_i) sys_rst_i |=>
        state_ff.pz_dir == 4'h0 && state_ff.pz_alt == 4'h0 && state_ff.pz_latch == 4'hf)
        else $error("port z registers not reset");
    a_pz_out_only: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        portz_pin_oe_o[1:0] == 2'b11)
        else $error("port z pins 0,1 not driven");
    // pins 0,1 have no direction bit, so it stays zero forever
    a_pz_dir_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_ff.pz_dir[1:0] == 2'b00)
        else $error("port z low direction bits set");
    a_pz_plain0: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !state_ff.pz_alt[0] |-> portz_pin_o[0] == state_ff.pz_latch[0])
        else $error("port z pin 0 not latch output");
    a_pz_plain1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !state_ff.pz_alt[1] |-> portz_pin_o[1] == state_ff.pz_latch[1])
        else $error("port z pin 1 not latch output");
    a_rd_external: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[0] && state_ff.pz_latch[0] && cpu_external_i)
        |-> portz_pin_o[0] == cpu_rd_n_i)
        else $error("read strobe missing on external access");
    a_rd_masked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[0] && state_ff.pz_latch[0] && !cpu_external_i)
        |-> portz_pin_o[0])
        else $error("read strobe on internal access");
    a_wr_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[1] && cpu_external_i) |-> portz_pin_o[1] == cpu_wr_n_i)
        else $error("write strobe missing on external access");
    a_hwr_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[2] && state_ff.pz_dir[2] && cpu_external_i)
        |-> portz_pin_oe_o[2] && portz_pin_o[2] == cpu_hwr_n_i)
        else $error("upper byte strobe not on pin 2");
    a_hwr_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[2] && !state_ff.pz_dir[2]) |-> !portz_pin_oe_o[2])
        else $error("reserved pin 2 setting drives");
    a_rw_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[3] && !state_ff.pz_dir[3])
        |-> portz_pin_oe_o[3] && portz_pin_o[3] == cpu_rw_i)
        else $error("read/write not on pin 3");
    a_rw_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff.pz_alt[3] && state_ff.pz_dir[3]) |-> !portz_pin_oe_o[3])
        else $error("reserved pin 3 setting drives");
    a_pz_plain_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!state_ff.pz_alt[2] && state_ff.pz_dir[2])
        |-> portz_pin_oe_o[2] && portz_pin_o[2] == state_ff.pz_latch[2])
        else $error("port z pin 2 not a plain output");
    // pull-up only where no driver fights it; outputs never pull
    a_pullup_on: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !portz_pin_oe_o[3] |-> portz_pullup_o[3] == state_ff.pz_latch[3])
        else $error("pin 3 pull-up not from latch");
    a_pullup_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        portz_pin_oe_o[2] |-> !portz_pullup_o[2])
        else $error("pull-up on a driven pin 2");
    a_no_pull_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        portz_pullup_o[1:0] == 2'b00)
        else $error("pull-up on output-only pins");

    c_rd_external: cover property (@(posedge clk_i) state_ff.pz_alt[0] && cpu_external_i);
    c_capture: cover property (@(posedge clk_i) timer4_capture_in0_o);
    c_serial: cover property (@(posedge clk_i) portb_pin_oe_o[0] && state_ff.pb_alt2[0]);
    c_hwr: cover property (@(posedge clk_i) state_ff.pz_alt[2] && portz_pin_oe_o[2]);
    c_rw: cover property (@(posedge clk_i) state_ff.pz_alt[3] && portz_pin_oe_o[3]);
endmodule // dpm_port_mux
`default_nettype wire

// ### design/dpm_pkg.sv
// Purpose: constants for the dual pin port and function mux
// Assumes: avalon-mm register slave, byte-wide registers in low bits of word
// Notes:   printed offsets are not all multiples of four, so byte addr = 4 * index
//
// Notes on behaviour
// - port b latch ones, pins inputs at reset
// - port b direction and alternate cleared at reset
// - first alternate only when alternate bit written one; second alternate needs it zero
// - pins 0,1 input alternate feed capture and irq
// - pins 2,3 output alternate drive timer flops
// - second alternate puts serial data/clock on 0,1
// - bit x controls pin x; others reserved
// - port b data read returns pin levels
// - port z pins 0,1 output-only, 2,3 bidirectional
// - port z reset: latch ones, pins 0,1 high
// - read strobe always when latch bit zero
// - read strobe only external when latch one
// - write strobe only during external accesses
// - pin 2 upper-byte strobe when function and direction
// - input pin latch bit selects pull-up
package dpm_pkg;
    // ----------------------------------------
    // register indices and address width
    // ----------------------------------------
    localparam logic [7:0] IDX_PB_DATA  = 8'h2c;
    localparam logic [7:0] IDX_PB_ALT2  = 8'h2d;
    localparam logic [7:0] IDX_PB_DIR   = 8'h2e;
    localparam logic [7:0] IDX_PB_ALT   = 8'h2f;
    localparam logic [7:0] IDX_PZ_DATA  = 8'h7d;
    localparam logic [7:0] IDX_PZ_DIR   = 8'h7e;
    localparam logic [7:0] IDX_PZ_ALT   = 8'h7f;
    localparam int         ADDR_W       = 10;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [3:0] RST_LATCH    = 4'hf;
    localparam logic [3:0] RST_CTRL     = 4'h0;
    localparam logic [1:0] RST_ALT2     = 2'h0;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage : dpm_pkg

// ### tb/dpm_ext_model.sv
// Purpose: far side of the pins, resolves every pad from all drivers
// Assumes: outside parts drive port b always, port z only when enabled
// Notes:   an undriven pad without pull-up flickers so stale values show
`timescale 1ns/1ps
`default_nettype none
module dpm_ext_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] pb_out_i,
    input  wire logic [3:0] pb_oe_i,
    input  wire logic [3:0] pz_out_i,
    input  wire logic [3:0] pz_oe_i,
    input  wire logic [3:0] pz_pu_i,
    input  wire logic [3:0] ext_b_i,
    input  wire logic [3:0] ext_z_i,
    input  wire logic [3:0] ext_z_en_i,
    output logic      [3:0] pb_pad_o,
    output logic      [3:0] pz_pad_o
);
    logic [3:0] flick_ff = 4'h5;
    // ----------------------------------------
    // pad resolution
    // ----------------------------------------
    // a floating pad is never left at its last level, a stale read would pass
    always @(posedge clk_i) flick_ff <= ~flick_ff;
    assign pb_pad_o = (pb_oe_i & pb_out_i) | (~pb_oe_i & ext_b_i);
    assign pz_pad_o = (pz_oe_i & pz_out_i) | (~pz_oe_i & ((ext_z_en_i & ext_z_i)
                    | (~ext_z_en_i & (pz_pu_i | flick_ff))));
endmodule // dpm_ext_model
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: register and pin-function tests of the port mux
// Assumes: one wait state per access, pins seen through a 2-flop sync
// Notes:   control registers get plain writes only; one read of direction checks it reads zero
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 0, sys_rst_i = 1, rd = 0, wr = 0, rd_n = 1, wr_n = 1, hwr_n = 1, rw = 0;
    logic ext = 0, fo0 = 0, fo1 = 0, sd = 1, sd_oe = 0, sc = 1, sc_oe = 0, sd_o, sc_o, wt;
    logic [9:0] adr = 0;
    logic [31:0] wd = 0, rdat, q;
    logic [3:0] pbi, pbo, pboe, pzi, pzo, pzoe, pzpu, cap, ext_b = 4'ha;
    int err_count = 0, n_checks = 0, cyc = 0;
    dpm_port_mux dpm_port_mux_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .portb_pin_i(pbi), .portb_pin_o(pbo),
        .portb_pin_oe_o(pboe), .portz_pin_i(pzi), .portz_pin_o(pzo), .portz_pin_oe_o(pzoe),
        .portz_pullup_o(pzpu), .timer4_capture_in0_o(cap[0]), .timer4_capture_in1_o(cap[1]),
        .ext_irq_nine_o(cap[2]), .ext_irq_ten_o(cap[3]), .timer4_flop_out0_i(fo0),
        .timer4_flop_out1_i(fo1), .serial_bus_data_line_i(sd), .serial_bus_data_oe_i(sd_oe),
        .serial_bus_data_line_o(sd_o), .serial_bus_clock_line_i(sc),
        .serial_bus_clock_oe_i(sc_oe), .serial_bus_clock_line_o(sc_o), .cpu_rd_n_i(rd_n),
        .cpu_wr_n_i(wr_n), .cpu_hwr_n_i(hwr_n), .cpu_rw_i(rw), .cpu_external_i(ext));
    dpm_ext_model dpm_ext_model_i (.clk_i(clk_i), .pb_out_i(pbo), .pb_oe_i(pboe),
        .pz_out_i(pzo), .pz_oe_i(pzoe), .pz_pu_i(pzpu), .ext_b_i(ext_b), .ext_z_i(4'h0),
        .ext_z_en_i(4'h0), .pb_pad_o(pbi), .pz_pad_o(pzi));
    // ----------------------------------------
    // clock, timeout, closing report
    // ----------------------------------------
    initial forever #2.5 clk_i = ~clk_i;
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // bound is about forty times the 120 or so cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic acc(input logic we, input logic [7:0] idx, input logic [3:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr <= {idx, 2'b00};
        wr <= we;
        rd <= ~we;
        wd <= {28'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wt !== 1'b0 && n < 50);
        if (n >= 50) err_count++;
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        settle();
        chk(pboe, 4'h0, "pb oe reset");
        chk({pzpu[3:2], pzoe, pzo[1:0]}, 8'hcf, "pz reset");
        acc(0, dpm_pkg::IDX_PB_DATA, 0);
        chk(q[3:0], 4'ha, "pb pins read");
        acc(0, dpm_pkg::IDX_PB_DIR, 0);
        chk(q, 32'h0, "wo read");
        acc(0, 8'h10, 0);
        chk(q, 32'h0, "unmapped read");
        acc(1, dpm_pkg::IDX_PB_DATA, 4'h5);
        acc(1, dpm_pkg::IDX_PB_DIR, 4'hf);
        settle();
        acc(0, dpm_pkg::IDX_PB_DATA, 0);
        chk({pboe, q[3:0]}, 8'hf5, "pb plain out");
        acc(1, dpm_pkg::IDX_PB_DIR, 4'h0);
        acc(1, dpm_pkg::IDX_PB_ALT, 4'h3);
        settle();
        chk(cap, 4'ha, "capture irq");
        ext_b <= 4'h1;
        settle();
        chk(cap, 4'h5, "capture irq 2");
        acc(1, dpm_pkg::IDX_PB_DIR, 4'hf);
        acc(1, dpm_pkg::IDX_PB_ALT, 4'hf);
        fo0 <= 1'b1;
        settle();
        chk({pboe, pbo[3:2], cap}, 10'h310, "timer out");
        acc(1, dpm_pkg::IDX_PB_DIR, 4'h3);
        acc(1, dpm_pkg::IDX_PB_ALT, 4'h0);
        acc(1, dpm_pkg::IDX_PB_ALT2, 4'h3);
        sd <= 1'b0;
        sd_oe <= 1'b1;
        settle();
        chk({pboe[1:0], pbo[0], sd_o, sc_o}, 5'h08, "serial bus");
        $display("port b tests done");
        acc(1, dpm_pkg::IDX_PZ_DATA, 4'h4);
        settle();
        chk({pzo[1:0], pzpu[3:2]}, 4'h1, "pz latch out pullup");
        acc(1, dpm_pkg::IDX_PZ_ALT, 4'h3);
        rd_n <= 1'b0;
        wr_n <= 1'b0;
        settle();
        chk(pzo[1:0], 2'h2, "internal strobes");
        ext <= 1'b1;
        settle();
        chk(pzo[1:0], 2'h0, "external strobes");
        acc(1, dpm_pkg::IDX_PZ_DATA, 4'h1);
        settle();
        chk(pzo[0], 1'b0, "rd external latch 1");
        ext <= 1'b0;
        settle();
        chk(pzo[0], 1'b1, "rd internal latch 1");
        acc(1, dpm_pkg::IDX_PZ_ALT, 4'h4);
        settle();
        chk(pzoe[2], 1'b0, "hwr reserved");
        acc(1, dpm_pkg::IDX_PZ_DIR, 4'h4);
        hwr_n <= 1'b0;
        ext <= 1'b1;
        settle();
        chk({pzoe[2], pzo[2]}, 2'h2, "hwr strobe");
        acc(1, dpm_pkg::IDX_PZ_DIR, 4'h0);
        acc(1, dpm_pkg::IDX_PZ_ALT, 4'h8);
        rw <= 1'b1;
        settle();
        chk({pzoe[3], pzo[3]}, 2'h3, "rw high");
        rw <= 1'b0;
        settle();
        chk({pzoe[3], pzo[3]}, 2'h2, "rw low");
        $display("port z tests done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
